// ==== hpd_pkg.sv ====
// ==========================================================================
// port data space constants
package hpd_pkg;

  // ========================================================================
  // geometry
  localparam int unsigned NUM_PORTS  = 3;
  localparam int unsigned PORT_WIDTH = 16;
  localparam int unsigned AUX_WIDTH  = 8;
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned BUS_WIDTH  = 32;

  // ========================================================================
  // byte offsets in the port space
  localparam logic [3:0] OFS_PORT2_DATA = 4'h0;
  localparam logic [3:0] OFS_PORT1_DATA = 4'h4;
  localparam logic [3:0] OFS_PORT0_DATA = 4'h8;
  localparam logic [3:0] OFS_AUX_OUT    = 4'hC;
  localparam logic [3:0] OFS_AUX_IN     = 4'hD;

  // word index (address bits 3:2) of each slot
  localparam logic [1:0] WIDX_PORT2 = 2'h0;
  localparam logic [1:0] WIDX_PORT1 = 2'h1;
  localparam logic [1:0] WIDX_PORT0 = 2'h2;
  localparam logic [1:0] WIDX_AUX   = 2'h3;

  // ========================================================================
  // byte enables
  localparam logic [3:0] BE_FULL_WORD = 4'hF;
  localparam logic [1:0] BE_LANE_NONE = 2'h0;

  // ========================================================================
  // aux output register fields
  localparam int unsigned AUX_STROBE_LSB = 0;
  localparam int unsigned AUX_GEN_LSB    = 3;
  localparam int unsigned AUX_GEN_WIDTH  = 5;

  // ========================================================================
  // reset values
  localparam logic [15:0] PORT_DATA_RESET = 16'h0000;
  localparam logic [7:0]  AUX_OUT_RESET   = 8'h00;

  // ========================================================================
  // direction and handshake protocol encodings
  localparam logic       DIR_INPUT       = 1'b0;
  localparam logic       DIR_OUTPUT      = 1'b1;
  localparam logic [1:0] HS_PROTO_NONE   = 2'h0;
  localparam logic [1:0] HS_PROTO_INTLK  = 2'h2;
  localparam logic [1:0] HS_PROTO_PULSED = 2'h3;

endpackage : hpd_pkg

// ==== hpd_port_lane.sv ====
`timescale 1ns/10ps
// ==========================================================================
// one 16-bit handshake port: data word, pin drive, fifo strobes
module hpd_port_lane (
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic                           direction,
  input  wire logic                           wrStrobe,
  input  wire logic                           rdStrobe,
  input  wire logic [hpd_pkg::PORT_WIDTH-1:0] wrWord,
  input  wire logic [hpd_pkg::PORT_WIDTH-1:0] pinIn,
  output logic      [hpd_pkg::PORT_WIDTH-1:0] readWord,
  output logic      [hpd_pkg::PORT_WIDTH-1:0] pinOut,
  output logic                                pinOe,
  output logic                                fifoPush,
  output logic                                fifoPop
);

  import hpd_pkg::*;

  logic [PORT_WIDTH-1:0] dataQ;

  // ========================================================================
  // data word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dataQ <= PORT_DATA_RESET;
    end else if (wrStrobe) begin
      dataQ <= wrWord;
    end
  end

  // ========================================================================
  // pin drive, one data bit per line, one output enable for the whole port
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut <= PORT_DATA_RESET;
      pinOe  <= 1'b0;
    end else begin
      pinOut <= wrStrobe ? wrWord : dataQ;
      pinOe  <= (direction == DIR_OUTPUT);
    end
  end

  // input mode returns the lines, output mode the stored word
  always_comb begin
    readWord = (direction == DIR_OUTPUT) ? dataQ : pinIn;
  end

  // ========================================================================
  // one pulse per word moved to or from the fifo
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fifoPush <= 1'b0;
      fifoPop  <= 1'b0;
    end else begin
      fifoPush <= wrStrobe;
      fifoPop  <= rdStrobe;
    end
  end

endmodule : hpd_port_lane

// ==== hpd_port_data_space.sv ====
`timescale 1ns/10ps
module hpd_port_data_space
  import hpd_pkg::*;
(
  input  wire logic                                  clk,
  input  wire logic                                  rst_b,
  input  wire logic                                  lbReq,
  input  wire logic                                  lbWr,
  input  wire logic [hpd_pkg::ADDR_WIDTH-1:0]        lbAddr,
  input  wire logic [3:0]                            lbBe,
  input  wire logic [hpd_pkg::BUS_WIDTH-1:0]         lbWrData,
  output logic      [hpd_pkg::BUS_WIDTH-1:0]         lbRdData,
  output logic                                       lbAck,
  input  wire logic [hpd_pkg::NUM_PORTS-1:0]         portDirection,
  input  wire logic [hpd_pkg::NUM_PORTS-1:0][1:0]    portProtocolSelect,
  input  wire logic [hpd_pkg::NUM_PORTS-1:0][15:0]   portPinIn,
  output logic      [hpd_pkg::NUM_PORTS-1:0][15:0]   portPinOut,
  output logic      [hpd_pkg::NUM_PORTS-1:0]         portPinOe,
  output logic      [hpd_pkg::NUM_PORTS-1:0]         portFifoPush,
  output logic      [hpd_pkg::NUM_PORTS-1:0]         portFifoPop,
  input  wire logic                                  strobeInPort0,
  input  wire logic                                  strobeInPort1,
  input  wire logic                                  strobeInPort2,
  input  wire logic [hpd_pkg::AUX_GEN_WIDTH-1:0]     auxGenIn,
  output logic                                       strobeOutPort0,
  output logic                                       strobeOutPort1,
  output logic                                       strobeOutPort2,
  output logic      [hpd_pkg::AUX_GEN_WIDTH-1:0]     auxGenOut,
  output logic      [hpd_pkg::NUM_PORTS-1:0]         hsInterlocked,
  output logic      [hpd_pkg::NUM_PORTS-1:0]         hsPulsed
);

  import hpd_pkg::*;

  typedef enum logic {ST_IDLE, ST_HIGH} hpd_seq_state_e;

  hpd_seq_state_e           stateQ;
  hpd_seq_state_e           stateD;
  logic [1:0]               savedPortQ;
  logic                     savedWrQ;
  logic [PORT_WIDTH-1:0]    savedHighQ;
  logic [AUX_WIDTH-1:0]     auxOutQ;
  logic [AUX_WIDTH-1:0]     auxInWord;
  logic [1:0]               wordIdx;
  logic                     reqPort;
  logic                     reqAux;
  logic                     reqSplit;
  logic                     xferValid;
  logic                     xferWr;
  logic                     xferHigh;
  logic [1:0]               xferPort;
  logic [PORT_WIDTH-1:0]    xferWrWord;
  logic                     finish;
  logic [NUM_PORTS-1:0]     laneWr;
  logic [NUM_PORTS-1:0]     laneRd;
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] laneReadWord;

  // ========================================================================
  // request decode
  always_comb begin
    wordIdx  = lbAddr[3:2];
    reqPort  = lbReq && (stateQ == ST_IDLE) && (wordIdx != WIDX_AUX);
    reqAux   = lbReq && (stateQ == ST_IDLE) && (wordIdx == WIDX_AUX);
    reqSplit = reqPort && (lbBe == BE_FULL_WORD);
  end

  // ========================================================================
  // halfword transfer sequencer
  always_comb begin
    stateD     = stateQ;
    xferValid  = 1'b0;
    xferWr     = 1'b0;
    xferHigh   = 1'b0;
    xferPort   = 2'h0;
    xferWrWord = lbWrData[15:0];
    finish     = 1'b0;
    case (stateQ)
      ST_IDLE: begin
        if (reqPort) begin
          xferValid = 1'b1;
          xferWr    = lbWr;
          // port number runs opposite to word index
          xferPort  = 2'(WIDX_PORT0 - wordIdx);
          // lower address halfword goes first on a split access
          xferHigh  = !reqSplit && (lbBe[1:0] == BE_LANE_NONE);
          xferWrWord = xferHigh ? lbWrData[31:16] : lbWrData[15:0];
          if (reqSplit) begin
            stateD = ST_HIGH;
          end else begin
            finish = 1'b1;
          end
        end else if (reqAux) begin
          finish = 1'b1;
        end
      end
      ST_HIGH: begin
        xferValid  = 1'b1;
        xferWr     = savedWrQ;
        xferHigh   = 1'b1;
        xferPort   = savedPortQ;
        xferWrWord = savedHighQ;
        finish     = 1'b1;
        stateD     = ST_IDLE;
      end
      default: begin
        stateD = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stateQ <= ST_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  // second half of a split access is held here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      savedPortQ <= 2'h0;
      savedWrQ   <= 1'b0;
      savedHighQ <= PORT_DATA_RESET;
    end else if (reqSplit) begin
      savedPortQ <= xferPort;
      savedWrQ   <= lbWr;
      savedHighQ <= lbWrData[31:16];
    end
  end

  // ========================================================================
  // port lanes
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_lane
      assign laneWr[gp] = xferValid && xferWr && (xferPort == 2'(gp));
      assign laneRd[gp] = xferValid && !xferWr && (xferPort == 2'(gp));

      hpd_port_lane u_lane (
        .clk       (clk),
        .rst_b     (rst_b),
        .direction (portDirection[gp]),
        .wrStrobe  (laneWr[gp]),
        .rdStrobe  (laneRd[gp]),
        .wrWord    (xferWrWord),
        .pinIn     (portPinIn[gp]),
        .readWord  (laneReadWord[gp]),
        .pinOut    (portPinOut[gp]),
        .pinOe     (portPinOe[gp]),
        .fifoPush  (portFifoPush[gp]),
        .fifoPop   (portFifoPop[gp])
      );

      // 01 is not a defined protocol and acts as none
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          hsInterlocked[gp] <= 1'b0;
          hsPulsed[gp]      <= 1'b0;
        end else begin
          hsInterlocked[gp] <= (portProtocolSelect[gp] == HS_PROTO_INTLK);
          hsPulsed[gp]      <= (portProtocolSelect[gp] == HS_PROTO_PULSED);
        end
      end
    end
  endgenerate

  // ========================================================================
  // aux ports
  always_comb begin
    auxInWord = {auxGenIn, strobeInPort2, strobeInPort1, strobeInPort0};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      auxOutQ <= AUX_OUT_RESET;
    end else if (reqAux && lbWr && lbBe[0]) begin
      // lane 1 (input register) and lanes 2-3 (reserved) drop writes
      auxOutQ <= lbWrData[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobeOutPort0 <= 1'b0;
      strobeOutPort1 <= 1'b0;
      strobeOutPort2 <= 1'b0;
      auxGenOut      <= AUX_OUT_RESET[AUX_GEN_LSB +: AUX_GEN_WIDTH];
    end else begin
      strobeOutPort0 <= auxOutQ[AUX_STROBE_LSB];
      strobeOutPort1 <= auxOutQ[AUX_STROBE_LSB + 1];
      strobeOutPort2 <= auxOutQ[AUX_STROBE_LSB + 2];
      auxGenOut      <= auxOutQ[AUX_GEN_LSB +: AUX_GEN_WIDTH];
    end
  end

  // ========================================================================
  // read data and acknowledge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lbRdData <= '0;
    end else if (reqAux) begin
      // reserved lanes 2-3 read as zero
      lbRdData <= {16'h0000, auxInWord, auxOutQ};
    end else if (xferValid && !xferWr) begin
      if (xferHigh && (stateQ == ST_HIGH)) begin
        lbRdData[31:16] <= laneReadWord[xferPort];
      end else if (xferHigh) begin
        // single access on the upper lane, lower lane reads zero
        lbRdData        <= {laneReadWord[xferPort], 16'h0000};
      end else begin
        lbRdData        <= {16'h0000, laneReadWord[xferPort]};
      end
    end else if (reqPort) begin
      lbRdData <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lbAck <= 1'b0;
    end else begin
      lbAck <= finish;
    end
  end

endmodule : hpd_port_data_space

// ==== hpd_port_data_space_sva.sv ====
`timescale 1ns/10ps
// ==========================================================================
// port data space checker
module hpd_port_data_space_sva (
  input wire logic                                clk,
  input wire logic                                rst_b,
  input wire logic                                lbReq,
  input wire logic                                lbWr,
  input wire logic [hpd_pkg::ADDR_WIDTH-1:0]      lbAddr,
  input wire logic [3:0]                          lbBe,
  input wire logic [hpd_pkg::BUS_WIDTH-1:0]       lbWrData,
  input wire logic [hpd_pkg::BUS_WIDTH-1:0]       lbRdData,
  input wire logic                                lbAck,
  input wire logic [hpd_pkg::NUM_PORTS-1:0]       portDirection,
  input wire logic [hpd_pkg::NUM_PORTS-1:0][1:0]  portProtocolSelect,
  input wire logic [hpd_pkg::NUM_PORTS-1:0][15:0] portPinOut,
  input wire logic [hpd_pkg::NUM_PORTS-1:0]       portPinOe,
  input wire logic [hpd_pkg::NUM_PORTS-1:0]       portFifoPush,
  input wire logic                                strobeInPort0,
  input wire logic                                strobeInPort1,
  input wire logic                                strobeInPort2,
  input wire logic [hpd_pkg::AUX_GEN_WIDTH-1:0]   auxGenIn,
  input wire logic                                strobeOutPort0,
  input wire logic                                strobeOutPort1,
  input wire logic                                strobeOutPort2,
  input wire logic [hpd_pkg::AUX_GEN_WIDTH-1:0]   auxGenOut,
  input wire logic [hpd_pkg::NUM_PORTS-1:0]       hsInterlocked,
  input wire logic [hpd_pkg::NUM_PORTS-1:0]       hsPulsed
);
  import hpd_pkg::*;
  logic       splitQ, seenQ, upQ;
  logic [2:0] intlk, puls;
  wire take = lbReq && !splitQ;
  wire full = take && lbBe == BE_FULL_WORD && lbAddr[3:2] != WIDX_AUX;
  wire aux  = take && lbAddr[3:2] == WIDX_AUX;
  wire [7:0] auxOut = {auxGenOut, strobeOutPort2, strobeOutPort1, strobeOutPort0};
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      intlk[p] = portProtocolSelect[p] == HS_PROTO_INTLK;
      puls[p]  = portProtocolSelect[p] == HS_PROTO_PULSED;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      splitQ <= 1'b0;
      seenQ  <= 1'b0;
      upQ    <= 1'b0;
    end else begin
      splitQ <= full;
      seenQ  <= 1'b1;
      upQ    <= seenQ;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_auxAck; aux |=> lbAck; endproperty
  a_auxAck: assert property (p_auxAck) else $error("aux access not acked");
  property p_split; full |=> !lbAck ##1 lbAck; endproperty
  a_split: assert property (p_split) else $error("wide access timing");
  property p_splitPush; full && lbWr |=> (portFifoPush != 3'h0) [*2]; endproperty
  a_splitPush: assert property (p_splitPush) else $error("wide write pushes");
  property p_noAck; !lbReq && !splitQ |=> !lbAck; endproperty
  a_noAck: assert property (p_noAck) else $error("ack without access");
  property p_portWr;
    take && lbWr && lbAddr == OFS_PORT0_DATA && lbBe == 4'h3
      |=> portPinOut[0] == $past(lbWrData[15:0]) && portFifoPush[0];
  endproperty
  a_portWr: assert property (p_portWr) else $error("port word write");
  property p_oe; upQ |-> portPinOe == $past(portDirection); endproperty
  a_oe: assert property (p_oe) else $error("output enable");
  property p_auxOut;
    aux && lbWr && lbBe[0] ##1 !(lbReq && lbWr && lbAddr[3:2] == WIDX_AUX)
      |=> auxOut == $past(lbWrData[7:0], 2);
  endproperty
  a_auxOut: assert property (p_auxOut) else $error("aux output value");
  property p_auxIn;
    aux && !lbWr |=> lbRdData[31:16] == 16'h0000 && lbRdData[15:8]
      == $past({auxGenIn, strobeInPort2, strobeInPort1, strobeInPort0});
  endproperty
  a_auxIn: assert property (p_auxIn) else $error("aux input read");
  property p_resv; aux && lbWr && lbBe == 4'hC |=> ##1 $stable(auxOut); endproperty
  a_resv: assert property (p_resv) else $error("reserved write took effect");
  property p_proto; upQ |-> hsInterlocked == $past(intlk) && hsPulsed == $past(puls); endproperty
  a_proto: assert property (p_proto) else $error("protocol decode");
  c_wideWr: cover property (full && lbWr);
  c_auxRd: cover property (aux && !lbWr);
  c_pulsed: cover property (hsPulsed == 3'h7);
endmodule : hpd_port_data_space_sva

bind hpd_port_data_space hpd_port_data_space_sva u_sva (.*);

// ==== hpd_ext_dev.sv ====
`timescale 1ns/10ps
// ==========================================================================
// far-side parallel device
module hpd_ext_dev (
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  input  wire logic [hpd_pkg::NUM_PORTS-1:0][15:0] pinOut,
  input  wire logic [hpd_pkg::NUM_PORTS-1:0]       pinOe,
  input  wire logic [hpd_pkg::NUM_PORTS-1:0]       strobeOut,
  input  wire logic [hpd_pkg::AUX_GEN_WIDTH-1:0]   genOut,
  input  wire logic [hpd_pkg::NUM_PORTS-1:0][15:0] devWord,
  output logic      [hpd_pkg::NUM_PORTS-1:0][15:0] pinIn,
  output logic      [hpd_pkg::NUM_PORTS-1:0]       strobeIn,
  output logic      [hpd_pkg::AUX_GEN_WIDTH-1:0]   genIn
);
  import hpd_pkg::*;
  // wire level: block drives when enabled, device otherwise
  always_comb begin
    for (int p = 0; p < 3; p++) pinIn[p] = pinOe[p] ? pinOut[p] : devWord[p];
  end
  // strobes echoed back one cycle later as acknowledge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) strobeIn <= 3'h0;
    else strobeIn <= strobeOut;
  end
  assign genIn = ~genOut;
endmodule : hpd_ext_dev

// ==== handshake_port_data_space_tb.sv ====
`timescale 1ns/10ps
// ==========================================================================
// testbench
module handshake_port_data_space_tb;
  import hpd_pkg::*;
  logic clk, rst_b, lbReq, lbWr, lbAck;
  logic [3:0]  lbAddr, lbBe;
  logic [31:0] lbWrData, lbRdData, rd;
  logic [2:0]  dir, push, pop, oe, sOut, sIn, intlk, puls;
  logic [2:0][1:0]  sel;
  logic [2:0][15:0] pIn, pOut, devWord;
  logic [4:0]  gOut, gIn;
  int n_mismatch, cmp_count, cycles, popCnt;
  logic [15:0] pushLog[$];
  hpd_port_data_space dut (.clk(clk), .rst_b(rst_b), .lbReq(lbReq), .lbWr(lbWr),
    .lbAddr(lbAddr), .lbBe(lbBe), .lbWrData(lbWrData), .lbRdData(lbRdData),
    .lbAck(lbAck), .portDirection(dir), .portProtocolSelect(sel), .portPinIn(pIn),
    .portPinOut(pOut), .portPinOe(oe), .portFifoPush(push), .portFifoPop(pop),
    .strobeInPort0(sIn[0]), .strobeInPort1(sIn[1]), .strobeInPort2(sIn[2]),
    .auxGenIn(gIn), .strobeOutPort0(sOut[0]), .strobeOutPort1(sOut[1]),
    .strobeOutPort2(sOut[2]), .auxGenOut(gOut), .hsInterlocked(intlk), .hsPulsed(puls));
  hpd_ext_dev u_dev (.clk(clk), .rst_b(rst_b), .pinOut(pOut), .pinOe(oe),
    .strobeOut(sOut), .genOut(gOut), .devWord(devWord), .pinIn(pIn),
    .strobeIn(sIn), .genIn(gIn));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (push[2] === 1'b1) pushLog.push_back(pOut[2]);
    if (pop[2] === 1'b1) popCnt++;
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    lbReq <= 1'b1;
    lbWr <= w;
    lbAddr <= a;
    lbBe <= be;
    lbWrData <= wd;
    @(posedge clk);
    lbReq <= 1'b0;
    #1;
    while (lbAck !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("ack", n < 8, 1'b1);
    rd = lbRdData;
  endtask : bus
  task automatic s_reset;
    for (int s = 0; s < 3; s++) begin
      bus(1'b0, 4'(4 * s), 4'hF, 32'h0);
      chk("port reset", rd, 32'h0);
    end
    bus(1'b0, OFS_AUX_OUT, 4'hF, 32'h0);
    chk("aux reset", rd, 32'h0000F800);
  endtask : s_reset
  task automatic s_alias;
    for (int p = 0; p < 3; p++) begin
      bus(1'b1, 4'(8 - 4 * p), 4'h3, 32'hA5C0 + p);
      chk("pins", pOut[p], 16'hA5C0 + p);
      bus(1'b0, 4'(8 - 4 * p), 4'h3, 32'h0);
      chk("low read", rd, 32'hA5C0 + p);
      bus(1'b0, 4'(10 - 4 * p), 4'hC, 32'h0);
      chk("alias", rd, (32'hA5C0 + p) << 16);
    end
  endtask : s_alias
  task automatic s_split;
    int pops;
    pushLog.delete();
    bus(1'b1, OFS_PORT2_DATA, 4'hF, 32'hBEEF1234);
    @(posedge clk);
    #1;
    chk("push count", pushLog.size(), 2);
    chk("first half", pushLog[0], 16'h1234);
    chk("second half", pushLog[1], 16'hBEEF);
    pops = popCnt;
    bus(1'b0, OFS_PORT2_DATA, 4'hF, 32'h0);
    chk("wide read", rd, 32'hBEEFBEEF);
    @(posedge clk);
    #1;
    chk("pop count", popCnt - pops, 2);
  endtask : s_split
  task automatic s_input;
    @(posedge clk);
    dir <= 3'b110;
    repeat (2) @(posedge clk);
    chk("oe", oe, 3'b110);
    bus(1'b0, OFS_PORT0_DATA, 4'hF, 32'h0);
    chk("input read", rd, 32'h3C963C96);
  endtask : s_input
  task automatic s_aux;
    bus(1'b1, OFS_AUX_OUT, 4'h1, 32'hA5);
    repeat (2) @(posedge clk);
    chk("strobes", {gOut, sOut}, 8'hA5);
    bus(1'b1, 4'hE, 4'hC, 32'hFFFFFFFF);
    bus(1'b0, OFS_AUX_IN, 4'h2, 32'h0);
    chk("aux read", rd, 32'h00005DA5);
    bus(1'b0, 4'hE, 4'hC, 32'h0);
    chk("reserved", rd & 32'hFFFF0000, 32'h0);
  endtask : s_aux
  task automatic s_proto;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      sel <= {3{2'(c)}};
      repeat (2) @(posedge clk);
      chk("intlk", intlk, (c == 2) ? 3'h7 : 3'h0);
      chk("pulsed", puls, (c == 3) ? 3'h7 : 3'h0);
    end
  endtask : s_proto
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  initial begin
    {lbReq, lbWr, lbAddr, lbBe, lbWrData, sel, rst_b} = '0;
    dir = 3'b111;
    devWord = {16'h0, 16'h0, 16'h3C96};
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    s_reset();
    s_alias();
    s_split();
    s_input();
    s_aux();
    s_proto();
    close_out();
  end
endmodule : handshake_port_data_space_tb
